// ==== logic/codec_iface_buffer_status.sv ====
// Buffer control, slot gating and status of the serial codec interface.
// Assumes a free or framed bit clock on a pin, far slower than aclk.
//
// Chosen here: the register offsets and register access over AXI4-Lite.
`timescale 1ns/10ps
module codec_iface_buffer_status (
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // AXI4-Lite write channels
   input wire logic [7:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   // AXI4-Lite read channels
   input wire logic [7:0] araddr,
   input wire logic arvalid,
   output logic arready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   // Codec link
   input wire logic serial_bit_clock,
   input wire logic frame_sync_pin_in,
   output logic frame_sync_pin_out,
   output logic frame_sync_pin_oe,
   input wire logic serial_data_in,
   output logic serial_data_out,
   output logic serial_data_oe,
   // System events
   input wire logic cpu_sleep,
   output logic iface_irq_flag,
   output logic dma_req,
   output logic wake_irq
);
   localparam int DW = codec_iface_pkg::DATA_W;
   localparam int NW = codec_iface_pkg::NUM_WORDS;
   typedef logic [DW-1:0] word_t;

   logic [2:0] pin_clean;
   logic bclk_s, fs_s, sdi_s;
   word_t ctrl_reg, ctrl_next, tx_en_reg, tx_en_next, rx_en_reg, rx_en_next;
   word_t tx_buf_reg [NW], tx_buf_next [NW], tx_sh_reg [NW], tx_sh_next [NW];
   word_t rx_buf_reg [NW], rx_buf_next [NW], rx_sh_reg [NW], rx_sh_next [NW];
   logic [NW-1:0] fresh_reg, fresh_next, unf_reg, unf_next, used;
   logic [NW-1:0] unread_reg, unread_next, ovf_reg, ovf_next;
   logic tx_empty_reg, tx_empty_next, rx_full_reg, rx_full_next;
   logic [1:0] addr_reg, addr_next, buffer_length_sel;
   logic [3:0] slot_reg, slot_next, bit_reg, bit_next, flen;
   logic active_reg, active_next, fs_seen_reg, fs_seen_next;
   logic bclk_q_reg, load_pend_reg, load_pend_next;
   word_t tx_shift_reg, tx_shift_next, rx_shift_reg, rx_shift_next;
   logic fs_out_reg, fs_out_next, sdo_reg, sdo_next, sdo_oe_reg, sdo_oe_next;
   logic irq_reg, irq_next, dma_reg, dma_next, wake_reg, wake_next;
   logic aw_full_reg, aw_full_next, w_full_reg, w_full_next;
   logic [7:0] waddr_reg, waddr_next;
   word_t wval_reg, wval_next;
   logic [1:0] wstb_reg, wstb_next;
   logic awready_reg, awready_next, wready_reg, wready_next;
   logic bvalid_reg, bvalid_next, arready_reg, arready_next;
   logic rvalid_reg, rvalid_next;
   logic fs_oe_reg, fs_oe_next;
   logic [1:0] bresp_reg, bresp_next, rresp_reg, rresp_next;
   logic [31:0] rdata_reg, rdata_next;
   logic slave, bclk_rise, bclk_fall, last_bit, restart, slot_done, xfer;
   logic sdi_eff, wr_fire, rd_fire;
   word_t wmask, rd_val;

   pin_sync3 #(.WIDTH(3)) u_sync (
      .aclk(aclk),
      .aresetn(aresetn),
      .pin_raw({serial_data_in, frame_sync_pin_in, serial_bit_clock}),
      .pin_clean(pin_clean)
   );
   assign bclk_s = pin_clean[0];
   assign fs_s = pin_clean[1];
   assign sdi_s = pin_clean[2];

   assign slave = ctrl_reg[codec_iface_pkg::CTRL_SLAVE];
   assign buffer_length_sel = ctrl_reg[codec_iface_pkg::CTRL_BUFFER_LENGTH_SEL_LSB +: 2];
   assign flen = ctrl_reg[codec_iface_pkg::CTRL_FLEN_LSB +: 4];
   assign bclk_rise = bclk_s && !bclk_q_reg;
   assign bclk_fall = !bclk_s && bclk_q_reg;
   assign last_bit = (bit_reg == 4'(DW - 1));
   assign restart = bclk_fall && (slave ? fs_seen_reg :
                    (last_bit && slot_reg == flen));
   assign slot_done = bclk_fall && last_bit && active_reg;
   assign sdi_eff = ctrl_reg[codec_iface_pkg::CTRL_LOOP] ?
                    sdo_reg : sdi_s;
   assign wr_fire = aw_full_reg && w_full_reg && !bvalid_reg;
   assign rd_fire = arvalid && arready_reg;
   assign wmask = {{8{wstb_reg[1]}}, {8{wstb_reg[0]}}};

   always_comb begin
      case (araddr[7:4])
         4'h0: begin
            case (araddr[3:2])
               2'h0: rd_val = ctrl_reg;
               2'h1: rd_val = tx_en_reg;
               2'h2: rd_val = rx_en_reg;
               default: rd_val = {4'h0, slot_reg, 4'h0, |ovf_reg,
                  rx_full_reg, |unf_reg, tx_empty_reg};
            endcase
         end
         codec_iface_pkg::OFS_TX_BUFFER_HI: rd_val = tx_buf_reg[araddr[3:2]];
         codec_iface_pkg::OFS_RX_BUFFER_HI: rd_val = rx_buf_reg[araddr[3:2]];
         default: rd_val = codec_iface_pkg::WORD_RESET;
      endcase
   end

   always_comb begin
      ctrl_next = ctrl_reg;
      tx_en_next = tx_en_reg;
      rx_en_next = rx_en_reg;
      tx_buf_next = tx_buf_reg;
      tx_sh_next = tx_sh_reg;
      rx_buf_next = rx_buf_reg;
      rx_sh_next = rx_sh_reg;
      fresh_next = fresh_reg;
      unf_next = unf_reg;
      unread_next = unread_reg;
      ovf_next = ovf_reg;
      tx_empty_next = tx_empty_reg;
      addr_next = addr_reg;
      slot_next = slot_reg;
      bit_next = bit_reg;
      active_next = active_reg;
      fs_seen_next = fs_seen_reg;
      load_pend_next = 1'b0;
      tx_shift_next = tx_shift_reg;
      rx_shift_next = rx_shift_reg;
      fs_out_next = fs_out_reg;
      xfer = 1'b0;
      aw_full_next = aw_full_reg;
      w_full_next = w_full_reg;
      waddr_next = waddr_reg;
      wval_next = wval_reg;
      wstb_next = wstb_reg;
      bvalid_next = bvalid_reg;
      bresp_next = bresp_reg;
      rvalid_next = rvalid_reg;
      rresp_next = rresp_reg;
      rdata_next = rdata_reg;
      for (int i = 0; i < NW; i++) begin
         used[i] = (2'(i) <= buffer_length_sel);
      end
      // Bus write: buffer writes clear before swap sets, so sets win
      if (awvalid && awready_reg) begin
         aw_full_next = 1'b1;
         waddr_next = awaddr;
      end
      if (wvalid && wready_reg) begin
         w_full_next = 1'b1;
         wval_next = wdata[15:0];
         wstb_next = wstrb[1:0];
      end
      if (wr_fire) begin
         aw_full_next = 1'b0;
         w_full_next = 1'b0;
         bvalid_next = 1'b1;
         bresp_next = codec_iface_pkg::RESP_OKAY;
         case (waddr_reg[7:4])
            4'h0: begin
               case (waddr_reg[3:2])
                  2'h0: ctrl_next = (ctrl_reg & ~wmask) | (wval_reg & wmask);
                  2'h1: tx_en_next = (tx_en_reg & ~wmask) | (wval_reg & wmask);
                  2'h2: rx_en_next = (rx_en_reg & ~wmask) | (wval_reg & wmask);
                  default: bresp_next = codec_iface_pkg::RESP_OKAY;
               endcase
            end
            codec_iface_pkg::OFS_TX_BUFFER_HI: begin
               tx_buf_next[waddr_reg[3:2]] =
                  (tx_buf_reg[waddr_reg[3:2]] & ~wmask) | (wval_reg & wmask);
               fresh_next[waddr_reg[3:2]] = 1'b1;
               unf_next[waddr_reg[3:2]] = 1'b0;
               tx_empty_next = 1'b0;
            end
            codec_iface_pkg::OFS_RX_BUFFER_HI:
               bresp_next = codec_iface_pkg::RESP_OKAY;
            default: bresp_next = codec_iface_pkg::RESP_SLVERR;
         endcase
      end else if (bvalid_reg && bready) begin
         bvalid_next = 1'b0;
      end
      // Bus read: reading a receive word clears its unread and overflow
      if (rd_fire) begin
         rvalid_next = 1'b1;
         rdata_next = {16'h0000, rd_val};
         rresp_next = (araddr[7:4] > codec_iface_pkg::OFS_RX_BUFFER_HI) ?
            codec_iface_pkg::RESP_SLVERR : codec_iface_pkg::RESP_OKAY;
         if (araddr[7:4] == codec_iface_pkg::OFS_RX_BUFFER_HI) begin
            unread_next[araddr[3:2]] = 1'b0;
            ovf_next[araddr[3:2]] = 1'b0;
         end
      end else if (rvalid_reg && rready) begin
         rvalid_next = 1'b0;
      end
      // Frame sync generator and slot timing
      if (bclk_rise) begin
         rx_shift_next = {rx_shift_reg[DW-2:0], sdi_eff};
         if (slave && fs_s) begin
            fs_seen_next = 1'b1;
         end
      end
      if (slot_done) begin
         if (rx_en_reg[slot_reg]) begin
            rx_sh_next[addr_reg] = rx_shift_reg;
         end
         if (tx_en_reg[slot_reg] || rx_en_reg[slot_reg]) begin
            if (addr_reg == buffer_length_sel) begin
               addr_next = 2'h0;
               xfer = 1'b1;
            end else begin
               addr_next = addr_reg + 2'h1;
            end
         end
      end
      if (bclk_fall) begin
         tx_shift_next = {tx_shift_reg[DW-2:0], 1'b0};
         fs_out_next = 1'b0;
         if (restart) begin
            bit_next = 4'h0;
            slot_next = 4'h0;
            active_next = 1'b1;
            fs_seen_next = 1'b0;
            fs_out_next = !slave;
            load_pend_next = 1'b1;
         end else if (last_bit) begin
            bit_next = 4'h0;
            load_pend_next = 1'b1;
            if (slot_reg == flen) begin
               slot_next = 4'h0;
               active_next = 1'b0;
            end else begin
               slot_next = slot_reg + 4'h1;
            end
         end else begin
            bit_next = bit_reg + 4'h1;
         end
      end
      if (load_pend_reg) begin
         tx_shift_next = (active_reg && tx_en_reg[slot_reg]) ?
            tx_sh_reg[addr_reg] : codec_iface_pkg::WORD_RESET;
      end
      // Shadow swap at the buffer length boundary
      if (xfer) begin
         for (int i = 0; i < NW; i++) begin
            if (used[i]) begin
               tx_sh_next[i] = (fresh_reg[i] ||
                  ctrl_reg[codec_iface_pkg::CTRL_UNF_MODE]) ?
                  tx_buf_reg[i] : codec_iface_pkg::WORD_RESET;
               unf_next[i] = unf_next[i] | !fresh_reg[i];
               fresh_next[i] = fresh_next[i] && (waddr_reg[3:2] == 2'(i))
                  && wr_fire && (waddr_reg[7:4] == 4'h1);
               rx_buf_next[i] = rx_sh_next[i];
               ovf_next[i] = ovf_next[i] | unread_reg[i];
               unread_next[i] = 1'b1;
            end
         end
         tx_empty_next = 1'b1;
      end
      rx_full_next = xfer | (rx_full_reg & |(unread_next & used));
      irq_next = xfer;
      dma_next = xfer && ctrl_reg[codec_iface_pkg::CTRL_DMA_SEL];
      wake_next = cpu_sleep && (wake_reg || (xfer &&
         ctrl_reg[codec_iface_pkg::CTRL_BCLK_DIR]));
      sdo_next = active_reg && tx_en_reg[slot_reg] && tx_shift_reg[DW-1];
      sdo_oe_next = (active_reg && tx_en_reg[slot_reg]) ||
         !ctrl_reg[codec_iface_pkg::CTRL_IDLE_MODE];
      awready_next = !aw_full_next && !bvalid_next;
      wready_next = !w_full_next && !bvalid_next;
      arready_next = !rvalid_next;
      fs_oe_next = !ctrl_next[codec_iface_pkg::CTRL_SLAVE];
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ctrl_reg <= codec_iface_pkg::CTRL_RESET;
         tx_en_reg <= codec_iface_pkg::SLOT_EN_RESET;
         rx_en_reg <= codec_iface_pkg::SLOT_EN_RESET;
         for (int i = 0; i < NW; i++) begin
            tx_buf_reg[i] <= codec_iface_pkg::WORD_RESET;
            tx_sh_reg[i] <= codec_iface_pkg::WORD_RESET;
            rx_buf_reg[i] <= codec_iface_pkg::WORD_RESET;
            rx_sh_reg[i] <= codec_iface_pkg::WORD_RESET;
         end
         {fresh_reg, unf_reg, unread_reg, ovf_reg} <= '0;
         {tx_empty_reg, rx_full_reg} <= 2'h0;
         addr_reg <= 2'h0;
         {slot_reg, bit_reg} <= 8'h00;
         {active_reg, fs_seen_reg, bclk_q_reg, load_pend_reg} <= 4'h0;
         tx_shift_reg <= codec_iface_pkg::WORD_RESET;
         rx_shift_reg <= codec_iface_pkg::WORD_RESET;
         {fs_out_reg, sdo_reg, sdo_oe_reg} <= 3'h0;
         {irq_reg, dma_reg, wake_reg} <= 3'h0;
         fs_oe_reg <= 1'b1;
         {aw_full_reg, w_full_reg, bvalid_reg, rvalid_reg} <= 4'h0;
         {awready_reg, wready_reg, arready_reg} <= 3'h0;
         waddr_reg <= 8'h00;
         wval_reg <= codec_iface_pkg::WORD_RESET;
         wstb_reg <= 2'h0;
         {bresp_reg, rresp_reg} <= 4'h0;
         rdata_reg <= 32'h00000000;
      end else begin
         ctrl_reg <= ctrl_next;
         tx_en_reg <= tx_en_next;
         rx_en_reg <= rx_en_next;
         tx_buf_reg <= tx_buf_next;
         tx_sh_reg <= tx_sh_next;
         rx_buf_reg <= rx_buf_next;
         rx_sh_reg <= rx_sh_next;
         {fresh_reg, unf_reg} <= {fresh_next, unf_next};
         {unread_reg, ovf_reg} <= {unread_next, ovf_next};
         {tx_empty_reg, rx_full_reg} <= {tx_empty_next, rx_full_next};
         addr_reg <= addr_next;
         {slot_reg, bit_reg} <= {slot_next, bit_next};
         {active_reg, fs_seen_reg} <= {active_next, fs_seen_next};
         {bclk_q_reg, load_pend_reg} <= {bclk_s, load_pend_next};
         tx_shift_reg <= tx_shift_next;
         rx_shift_reg <= rx_shift_next;
         {fs_out_reg, sdo_reg, sdo_oe_reg} <= {fs_out_next, sdo_next,
            sdo_oe_next};
         {irq_reg, dma_reg, wake_reg} <= {irq_next, dma_next, wake_next};
         {aw_full_reg, w_full_reg} <= {aw_full_next, w_full_next};
         {bvalid_reg, rvalid_reg} <= {bvalid_next, rvalid_next};
         {awready_reg, wready_reg} <= {awready_next, wready_next};
         arready_reg <= arready_next;
         fs_oe_reg <= fs_oe_next;
         {waddr_reg, wval_reg, wstb_reg} <= {waddr_next, wval_next, wstb_next};
         {bresp_reg, rresp_reg, rdata_reg} <= {bresp_next, rresp_next,
            rdata_next};
      end
   end

   assign {awready, wready, arready} = {awready_reg, wready_reg, arready_reg};
   assign {bvalid, bresp, rvalid, rresp} = {bvalid_reg, bresp_reg,
      rvalid_reg, rresp_reg};
   assign rdata = rdata_reg;
   assign frame_sync_pin_out = fs_out_reg;
   assign frame_sync_pin_oe = fs_oe_reg;
   assign serial_data_out = sdo_reg;
   assign serial_data_oe = sdo_oe_reg;
   assign {iface_irq_flag, dma_req, wake_irq} = {irq_reg, dma_reg, wake_reg};

   property p_fs_master;
      @(posedge aclk) disable iff (!aresetn)
      (restart && !slave) |=> frame_sync_pin_out;
   endproperty
   a_fs_master: assert property (p_fs_master)
      else $error("master frame sync not emitted");
   property p_slot_range;
      @(posedge aclk) disable iff (!aresetn)
      (bclk_fall && last_bit && slot_reg == flen) |=> slot_reg == 4'h0;
   endproperty
   a_slot_range: assert property (p_slot_range)
      else $error("slot counter not wrapped at frame end");
   property p_addr_step;
      @(posedge aclk) disable iff (!aresetn)
      (slot_done && tx_en_reg[slot_reg] && addr_reg != buffer_length_sel)
      |=> addr_reg == $past(addr_reg) + 2'h1;
   endproperty
   a_addr_step: assert property (p_addr_step)
      else $error("address counter did not advance");
   property p_rx_gate;
      @(posedge aclk) disable iff (!aresetn)
      (slot_done && !rx_en_reg[slot_reg] && !xfer)
      |=> rx_sh_reg[$past(addr_reg)] == $past(rx_sh_reg[addr_reg]);
   endproperty
   a_rx_gate: assert property (p_rx_gate)
      else $error("receive shadow written in disabled slot");
   property p_swap;
      @(posedge aclk) disable iff (!aresetn)
      xfer |=> (addr_reg == 2'h0) && tx_empty_reg && rx_full_reg;
   endproperty
   a_swap: assert property (p_swap)
      else $error("shadow swap effects missing");
   property p_dma;
      @(posedge aclk) disable iff (!aresetn)
      $rose(dma_req) |-> iface_irq_flag && $past(xfer);
   endproperty
   a_dma: assert property (p_dma)
      else $error("dma request without transfer event");
   property p_unf;
      @(posedge aclk) disable iff (!aresetn)
      (xfer && !fresh_reg[0]) |=> unf_reg[0];
   endproperty
   a_unf: assert property (p_unf)
      else $error("underflow not flagged");
   property p_ovf;
      @(posedge aclk) disable iff (!aresetn)
      (xfer && unread_reg[0]) |=> ovf_reg[0];
   endproperty
   a_ovf: assert property (p_ovf)
      else $error("overflow not flagged");
   property p_idle_float;
      @(posedge aclk) disable iff (!aresetn)
      (!(active_reg && tx_en_reg[slot_reg]) &&
      ctrl_reg[codec_iface_pkg::CTRL_IDLE_MODE]) |=> !serial_data_oe;
   endproperty
   a_idle_float: assert property (p_idle_float)
      else $error("data pin driven in idle slot");
   property p_irq;
      @(posedge aclk) disable iff (!aresetn)
      xfer |=> iface_irq_flag ##1 !iface_irq_flag;
   endproperty
   a_irq: assert property (p_irq)
      else $error("interrupt pulse wrong");
endmodule

// ==== logic/codec_iface_pkg.sv ====
// Constants shared by the codec interface buffer and status block.
// Assumes a 32-bit AXI4-Lite register bus with byte addressing.
package codec_iface_pkg;
   // Data path sizes
   localparam int DATA_W = 16;
   localparam int NUM_WORDS = 4;
   localparam int NUM_SLOTS = 16;
   localparam int SLOT_W = 4;
   localparam int BIT_W = 4;
   localparam int BUF_AW = 2;
   localparam int AXI_AW = 8;
   localparam int SYNC_W = 3;
   // Register byte offsets, and upper address nibbles of the buffers
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_TX_SLOT = 8'h04;
   localparam logic [7:0] OFS_RX_SLOT = 8'h08;
   localparam logic [7:0] OFS_STATUS = 8'h0C;
   localparam logic [3:0] OFS_TX_BUFFER_HI = 4'h1;
   localparam logic [3:0] OFS_RX_BUFFER_HI = 4'h2;
   // Control register fields
   localparam int CTRL_SLAVE = 0;
   localparam int CTRL_LOOP = 1;
   localparam int CTRL_IDLE_MODE = 2;
   localparam int CTRL_UNF_MODE = 3;
   localparam int CTRL_BCLK_DIR = 4;
   localparam int CTRL_DMA_SEL = 5;
   localparam int CTRL_BUFFER_LENGTH_SEL_LSB = 8;
   localparam int CTRL_FLEN_LSB = 12;
   // Status register fields
   localparam int ST_TX_EMPTY = 0;
   localparam int ST_TX_UNF = 1;
   localparam int ST_RX_FULL = 2;
   localparam int ST_RX_OVF = 3;
   localparam int ST_SLOT_LSB = 8;
   // Reset values
   localparam logic [15:0] CTRL_RESET = 16'h0000;
   localparam logic [15:0] SLOT_EN_RESET = 16'h0000;
   localparam logic [15:0] WORD_RESET = 16'h0000;
   // Bus responses
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// ==== logic/pin_sync3.sv ====
// Three-stage pin synchroniser with agreement filter.
// Assumes inputs come from outside the aclk domain.
`timescale 1ns/10ps
module pin_sync3 #(
   parameter int WIDTH = 1
) (
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // Raw and filtered levels
   input wire logic [WIDTH-1:0] pin_raw,
   output logic [WIDTH-1:0] pin_clean
);
   logic [WIDTH-1:0] s1_reg, s2_reg, s3_reg, clean_reg;
   logic [WIDTH-1:0] clean_next;

   // Output moves only where stages two and three agree
   always_comb begin
      clean_next = clean_reg;
      for (int i = 0; i < WIDTH; i++) begin
         if (s2_reg[i] == s3_reg[i]) begin
            clean_next[i] = s3_reg[i];
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s1_reg <= '0;
         s2_reg <= '0;
         s3_reg <= '0;
         clean_reg <= '0;
      end else begin
         s1_reg <= pin_raw;
         s2_reg <= s1_reg;
         s3_reg <= s2_reg;
         clean_reg <= clean_next;
      end
   end

   assign pin_clean = clean_reg;
endmodule

// ==== bench/codec_link_model.sv ====
// Codec side of the serial link: bit clock, frame sync line, data in.
// Assumes the block is frame sync master unless it releases the pin.
`timescale 1ns/10ps
module codec_link_model (
   // Bench control
   input wire logic run,
   // Pins from the block
   input wire logic frame_sync_pin_out,
   input wire logic frame_sync_pin_oe,
   // Pins to the block
   output logic serial_bit_clock,
   output logic frame_sync_pin_in,
   output logic serial_data_in
);
   logic sdi_q = 1'b0;
   // Bit clock of 80 ns, stops low when the bench halts the link
   initial begin
      serial_bit_clock = 1'b0;
      #13;
      forever begin
         #40;
         if (run || serial_bit_clock) serial_bit_clock = ~serial_bit_clock;
      end
   end
   // Data toggles on falling edges so a stale level never passes
   always @(negedge serial_bit_clock) sdi_q <= ~sdi_q;
   assign serial_data_in = sdi_q;
   // Line pulled down whenever the block does not drive it
   assign frame_sync_pin_in = frame_sync_pin_oe ? frame_sync_pin_out : 1'b0;
endmodule

// ==== bench/codec_iface_buffer_status_tb.sv ====
// Self-checking bench for the codec interface buffer and status block.
// Assumes loopback traffic and a bench-run bit clock from the codec model.
`timescale 1ns/10ps
module codec_iface_buffer_status_tb;
   logic aclk = 1'b0, aresetn = 1'b0, run = 1'b0, cpu_sleep = 1'b0;
   logic [7:0] awaddr = 8'h00, araddr = 8'h00;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
   logic arvalid = 1'b0, rready = 1'b0;
   logic [31:0] wdata = 32'h0, rdata, d;
   logic [3:0] wstrb = 4'hF;
   logic [1:0] bresp, rresp, r;
   logic awready, wready, bvalid, arready, rvalid, serial_bit_clock;
   logic frame_sync_pin_in, frame_sync_pin_out, frame_sync_pin_oe;
   logic serial_data_in, serial_data_out, serial_data_oe;
   logic iface_irq_flag, dma_req, wake_irq;
   logic [15:0] w0, w1, v0, v1;
   int seed, miscompares = 0, n_compared = 0;
   always #2.5 aclk = ~aclk;
   codec_iface_buffer_status u_codec_iface_buffer_status (
      .aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid,
      .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata,
      .rresp, .rvalid, .rready, .serial_bit_clock, .frame_sync_pin_in,
      .frame_sync_pin_out, .frame_sync_pin_oe, .serial_data_in,
      .serial_data_out, .serial_data_oe, .cpu_sleep, .iface_irq_flag,
      .dma_req, .wake_irq);
   codec_link_model u_codec_link_model (
      .run, .frame_sync_pin_out, .frame_sync_pin_oe, .serial_bit_clock,
      .frame_sync_pin_in, .serial_data_in);
   // Flags in the order overflow, full, underflow, empty
   function automatic logic [31:0] st(input logic [3:0] ofue);
      return {28'h0, ofue};
   endfunction
   function automatic logic [15:0] ctl(input logic u, m, input logic [1:0] b);
      return {4'h2, 2'h0, b, 2'h0, m, 1'b1, u, 1'b0, 1'b1, 1'b0};
   endfunction
   function automatic logic [15:0] fill(input logic mode, logic [15:0] w);
      return mode ? w : 16'h0000;
   endfunction
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         miscompares++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [15:0] dv);
      int t;
      logic ah, wh, bh;
      t = 0;
      bh = 1'b0;
      awaddr <= a;
      wdata <= {16'h0000, dv};
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      while (!bh && t < 100) begin
         @(negedge aclk);
         ah = awvalid && awready === 1'b1;
         wh = wvalid && wready === 1'b1;
         bh = bvalid === 1'b1;
         @(posedge aclk);
         if (ah) awvalid <= 1'b0;
         if (wh) wvalid <= 1'b0;
         t++;
      end
      bready <= 1'b0;
      @(posedge aclk);
      if (!bh) miscompares++;
   endtask
   task automatic rd(input logic [7:0] a);
      int t;
      logic ah, rh;
      t = 0;
      rh = 1'b0;
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      while (!rh && t < 100) begin
         @(negedge aclk);
         ah = arvalid && arready === 1'b1;
         rh = rvalid === 1'b1;
         d = rdata;
         r = rresp;
         @(posedge aclk);
         if (ah) arvalid <= 1'b0;
         t++;
      end
      rready <= 1'b0;
      @(posedge aclk);
      if (!rh) miscompares++;
   endtask
   task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, m);
      rd(a);
      chk(d & m, exp);
      chk({30'h0, r}, {30'h0, codec_iface_pkg::RESP_OKAY});
   endtask
   task automatic wait_swap(input logic dma_exp);
      int t;
      logic hit;
      t = 0;
      hit = 1'b0;
      run <= 1'b1;
      while (!hit && t < 5000) begin
         @(negedge aclk);
         hit = iface_irq_flag === 1'b1;
         t++;
      end
      chk({31'h0, hit}, 32'h1);
      chk({31'h0, dma_req}, {31'h0, dma_exp});
      @(posedge aclk);
      run <= 1'b0;
      repeat (3) @(posedge aclk);
   endtask
   task automatic summarize();
      $display("compared %0d mismatches %0d", n_compared, miscompares);
      if (miscompares == 0 && n_compared > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   initial begin
      #250000;
      miscompares++;
      summarize();
   end
   initial begin
      seed = 4670;
      w0 = 16'($random(seed));
      w1 = 16'($random(seed));
      v0 = 16'($random(seed));
      v1 = 16'($random(seed));
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      repeat (2) @(posedge aclk);
      rd_chk(codec_iface_pkg::OFS_CTRL, 32'h0, 32'hFFFF);
      rd_chk(codec_iface_pkg::OFS_STATUS, 32'h0, 32'hF);
      rd(8'h40);
      chk({30'h0, r}, {30'h0, codec_iface_pkg::RESP_SLVERR});
      wr(codec_iface_pkg::OFS_TX_SLOT, 16'h0003);
      wr(codec_iface_pkg::OFS_RX_SLOT, 16'h0001);
      wr(codec_iface_pkg::OFS_CTRL, ctl(1'b1, 1'b0, 2'h1));
      rd_chk(codec_iface_pkg::OFS_CTRL, {16'h0, ctl(1'b1, 1'b0, 2'h1)},
         32'hFFFF);
      wr(8'h10, w0);
      wr(8'h14, w1);
      cpu_sleep <= 1'b1;
      wait_swap(1'b0);
      chk({31'h0, wake_irq}, 32'h1);
      // Halted in slot two: enabled slots zero and one are done
      chk({29'h0, frame_sync_pin_oe, serial_data_oe, serial_data_out},
         32'h6);
      cpu_sleep <= 1'b0;
      rd_chk(codec_iface_pkg::OFS_STATUS, st(4'b0101) | 32'h200,
         32'hF0F);
      chk({31'h0, wake_irq}, 32'h0);
      wait_swap(1'b0);
      rd_chk(codec_iface_pkg::OFS_STATUS, st(4'b1111), 32'hF);
      rd_chk(8'h20, {16'h0, fill(1'b1, w0)}, 32'hFFFF);
      rd_chk(8'h24, 32'h0, 32'hFFFF);
      rd_chk(codec_iface_pkg::OFS_STATUS, st(4'b0011), 32'hF);
      wr(codec_iface_pkg::OFS_CTRL, ctl(1'b0, 1'b0, 2'h1));
      wr(8'h10, v0);
      rd_chk(codec_iface_pkg::OFS_STATUS, st(4'b0010), 32'hF);
      wr(8'h14, v1);
      rd_chk(codec_iface_pkg::OFS_STATUS, st(4'b0000), 32'hF);
      wait_swap(1'b0);
      wait_swap(1'b0);
      rd_chk(8'h20, {16'h0, v0}, 32'hFFFF);
      wait_swap(1'b0);
      rd_chk(8'h20, {16'h0, fill(1'b0, v0)}, 32'hFFFF);
      // One-word length with DMA, idle slots left floating
      wr(codec_iface_pkg::OFS_CTRL, ctl(1'b0, 1'b1, 2'h0) | 16'h0004);
      wait_swap(1'b1);
      wait_swap(1'b1);
      chk({30'h0, serial_data_oe, serial_data_out}, 32'h0);
      summarize();
   end
endmodule
